// >>> bench/rfac_radio_model.sv
/*
 Far-side model of the radio and cipher core fed by the framer.
 Assumes one clock, a synchronous active-high reset, and one-cycle
 launch pulses from the framer.
*/
`timescale 1ns/1ps
`default_nettype none
module rfac_radio_model (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_tx_done,
	input wire logic i_rx_done,
	input wire logic [2:0] i_sec_level,
	output logic [15:0] o_tx_count,
	output logic [15:0] o_rx_count,
	output logic o_bad_level
);
	// Count launches; a stuck pulse shows up as extra frames
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			o_tx_count <= 16'h0000;
			o_rx_count <= 16'h0000;
			o_bad_level <= 1'b0;
		end
		else
		begin
			o_tx_count <= o_tx_count + {15'h0000, i_tx_done};
			o_rx_count <= o_rx_count + {15'h0000, i_rx_done};
			// Cipher core only knows levels 0 and 4
			if (i_sec_level != 3'h0 && i_sec_level != 3'h4)
				o_bad_level <= 1'b1;
		end
	end
endmodule : rfac_radio_model
`default_nettype wire

// >>> bench/tb.sv
/*
 Self-checking bench for the framer: random and corner configurations,
 transmit requests and receive decisions checked over AHB-Lite.
 Assumes rfac_map.svh on the include path and hready tied to hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rfac_map.svh"
module tb;
	localparam logic [63:0] SER = 64'h5A5A_1234_C3C3_0F0F; // Arbitrary
	logic clk, rst, hsel, hwrite;
	logic [31:0] haddr, hwdata, dhi, dlo;
	logic [1:0] htrans, hmode;
	logic [15:0] own, pan;
	logic enc, api;
	logic [7:0] cmp;
	wire logic hready, hresp, tx_done, rx_done, bad_lvl;
	wire logic [31:0] hrdata;
	wire logic [127:0] key;
	wire logic [2:0] sec;
	wire logic [15:0] tx_cnt, rx_cnt;
	int errors, compares, cycles, ntx, nrx;
	integer seed = 32'h660e;
	logic [31:0] r;
	logic [127:0] k;

	rfac_framer #(.SERIAL(SER)) u_dut (.i_clock(clk), .i_sys_rst(rst),
		.i_clk_en(1'b1), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
		.o_hrdata(hrdata), .o_cipher_key(key), .o_sec_level(sec),
		.o_tx_done(tx_done), .o_rx_done(rx_done));
	rfac_radio_model u_radio (.i_clock(clk), .i_sys_rst(rst),
		.i_tx_done(tx_done), .i_rx_done(rx_done), .i_sec_level(sec),
		.o_tx_count(tx_cnt), .o_rx_count(rx_cnt), .o_bad_level(bad_lvl));

	// Clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			end_of_test();
		end
	end

	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : check

	// One single AHB-Lite transfer; waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		check(n, q, e);
	endtask : rd_chk

	// Payload budget from the current options
	function automatic logic [6:0] max_pay(input logic e, input logic slg,
		input logic dlg, input logic [1:0] m, input logic c);
		logic [6:0] p;
		p = 7'h74;
		if (c)
			return e ? 7'h5F : 7'h64;
		if (e)
			p = p - 7'h05;
		if (slg)
			p = p - 7'h06;
		if (dlg)
			p = p - 7'h06;
		if (m == 2'h0 || m == 2'h3)
			p = p - (e ? 7'h04 : 7'h02);
		return p;
	endfunction : max_pay

	task automatic set_cfg(input logic [15:0] o, input logic [31:0] dhw,
		input logic [31:0] dlw, input logic [15:0] p, input logic [11:0] c);
		{own, dhi, dlo, pan} = {o, dhw, dlw, p};
		{cmp, hmode, api, enc} = c;
		wr(`RFAC_OWN_SHORT, {16'h0000, o});
		wr(`RFAC_DEST_HI, dhw);
		wr(`RFAC_DEST_LO, dlw);
		wr(`RFAC_PAN, {16'h0000, p});
		wr(`RFAC_CTRL, {16'h0000, c[11:4], 4'h0, c[3:0]});
		#1 check("sec", {29'h0, sec}, enc ? 32'h4 : 32'h0);
		rd_chk("ctrl", `RFAC_CTRL,
			{16'h0000, c[11:4], 4'h0, c[3:0]});
	endtask : set_cfg

	task automatic tx_case(input logic [7:0] ft, input logic [7:0] off);
		logic tdl, dlg, slg, bc, rej;
		logic [31:0] thi, tlo;
		logic [63:0] dst, src;
		logic [6:0] mx, lv, len;
		thi = $random(seed);
		tlo = thi[0] ? 32'h0000FFFF : $random(seed);
		tdl = !(dhi == 32'h0 && dlo[31:16] == 16'h0);
		dlg = api ? ft != 8'h01 : tdl;
		dst = api ? {thi, tlo} : {dhi, dlo};
		if (!dlg)
			dst = {48'h0, dst[15:0]};
		slg = enc || own == 16'hFFFF || own == 16'hFFFE;
		src = slg ? SER : {48'h0, own};
		bc = !dlg && dst[15:0] == 16'hFFFF;
		mx = max_pay(enc, slg, dlg, hmode, cmp[0]);
		lv = max_pay(enc, slg, tdl, hmode, cmp[0]);
		len = mx + off[6:0];
		rej = api && len > mx;
		wr(`RFAC_TXD_HI, thi);
		wr(`RFAC_TXD_LO, tlo);
		wr(`RFAC_TXREQ, {17'h0, len, ft});
		#1 check("tx_done", {31'h0, tx_done}, 32'h1);
		ntx++;
		rd_chk("txstat", `RFAC_TXSTAT,
			{6'h0, hmode == 2'h0 || hmode == 2'h3,
			enc ? 3'h4 : 3'h0, !bc && !hmode[0], pan == 16'hFFFF, bc,
			slg, dlg, rej,
			rej ? 16'h894A : 16'h0000});
		rd_chk("src_hi", `RFAC_TXSRC_HI, src[63:32]);
		rd_chk("src_lo", `RFAC_TXSRC_LO, src[31:0]);
		rd_chk("dst_hi", `RFAC_TXDST_HI, dst[63:32]);
		rd_chk("dst_lo", `RFAC_TXDST_LO, dst[31:0]);
		rd_chk("tx_pan", `RFAC_TXPAN, {16'h0, pan});
		rd_chk("maxpay", `RFAC_MAXPAY,
			{1'b0, len, 1'b0, mx, 9'h0, lv});
	endtask : tx_case

	task automatic rx_case(input logic es, input logic ss,
		input logic [15:0] ash);
		logic dr;
		logic [7:0] ty;
		dr = es != enc;
		if (!api || dr)
			ty = 8'h00;
		else if (!enc)
			ty = ss ? 8'h80 : 8'h81;
		else if (hmode == 2'h0 || hmode == 2'h3)
			ty = (ash == 16'hFFFE || ash == 16'hFFFF) ? 8'h80 : 8'h81;
		else
			ty = 8'h80;
		wr(`RFAC_RXINFO, {ash, 14'h0, ss, es});
		#1 check("rx_done", {31'h0, rx_done}, 32'h1);
		nrx++;
		rd_chk("rxres", `RFAC_RXRES, {22'h0, dr, !dr, ty});
	endtask : rx_case

	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// Main sequence: reset values, key, association, corners, random
	initial
	begin
		// Reset bit first; the rest of the bus idles at zero
		{rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 36'h0, 32'h0};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("hresp", {31'h0, hresp}, 32'h0);
		rd_chk("own_rst", `RFAC_OWN_SHORT, 32'h0);
		rd_chk("ctrl_rst", `RFAC_CTRL, 32'h0);
		rd_chk("unmapped", 8'h7C, 32'h0);
		k = {$random(seed), $random(seed), $random(seed), $random(seed)};
		for (int i = 0; i < 4; i++)
			wr(`RFAC_KEY0 + 8'(4 * i), k[32 * i +: 32]);
		#1 for (int i = 0; i < 4; i++)
			check("key", key[32 * i +: 32], k[32 * i +: 32]);
		rd_chk("key_rd", `RFAC_KEY0, 32'h0);
		set_cfg(16'h0012, 32'h0, 32'h0000_0034, 16'h1111, 12'h000);
		wr(`RFAC_ASSOC, 32'h1);
		own = 16'hFFFE;
		rd_chk("assoc", `RFAC_OWN_SHORT, 32'h0000FFFE);
		tx_case(8'h00, 8'h00);
		for (int i = 0; i < 18; i++)
		begin
			set_cfg(16'h0012, 32'h0, 32'h0000FFFF, 16'hFFFF,
				{7'h0, i >= 16, 2'(i / 2), 1'b1, 1'(i)});
			tx_case(8'h01, 8'h00);
			tx_case(8'h00, 8'h01);
			rx_case(1'(i), 1'b0, 16'h1234);
			rx_case(1'(i), 1'b1, 16'hFFFE);
			rx_case(!(1'(i)), 1'b1, 16'h0001);
		end
		for (int i = 0; i < 40; i++)
		begin
			r = $random(seed);
			set_cfg(r[1] ? r[31:16] : {15'h7FFF, r[0]},
				r[2] ? 32'h0 : $random(seed),
				r[3] ? {16'h0, r[4] ? 16'hFFFF : r[15:0]} : $random(seed),
				r[5] ? 16'hFFFF : r[31:16],
				{r[19:13], r[11] & r[12], r[10:9], r[7] | r[8], r[6]});
			tx_case(r[20] ? 8'h01 : {r[27:22], r[21], 1'b0}, 8'(r[26:23]) - 8'h06);
			rx_case(r[28], r[29], r[30] ? 16'hFFFF : r[15:0]);
		end
		@(posedge clk);
		#1 check("tx_count", {16'h0, tx_cnt}, ntx);
		check("rx_count", {16'h0, rx_cnt}, nrx);
		check("level", {31'h0, bad_lvl}, 32'h0);
		end_of_test();
	end
endmodule : tb
`default_nettype wire

// >>> src/rfac_framer.sv
/*
 Frame header builder and receive frame-type selector, with its
 configuration reached over an AHB-Lite slave (zero-wait writes,
 one wait state on reads).
 Assumes one master, word transfers only, and that the cipher core,
 radio and serial transport live outside and read the outputs here.
*/
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rfac_map.svh"
module rfac_framer #(
	// Factory serial number; value is arbitrary
	parameter logic [63:0] SERIAL = 64'h0123_4567_89AB_CDEF
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	output logic [127:0] o_cipher_key,
	output logic [2:0] o_sec_level,
	output logic o_tx_done,
	output logic o_rx_done
);
	import rfac_pkg::*;

	rfac_pkg::rfac_state_t st;
	rfac_pkg::rfac_state_t nxt_st;

	// Short addresses that stand for "use the long serial"
	function automatic logic rfac_no_short(input logic [15:0] a);
		return (a == `RFAC_BCAST) || (a == `RFAC_ASSOC_ADDR);
	endfunction : rfac_no_short

	// Header modes 0 and 3 carry the application header
	function automatic logic rfac_app_hdr(input logic [1:0] hm);
		return (hm == 2'h0) || (hm == 2'h3);
	endfunction : rfac_app_hdr

	// Payload budget for one set of header choices
	function automatic logic [6:0] rfac_max_pay(
		input logic enc,
		input logic slong,
		input logic dlong,
		input logic [1:0] hm,
		input logic cmp
	);
		logic [6:0] m;
		m = `RFAC_PAY_BASE;
		if (enc)
			m = m - `RFAC_RED_ENC;
		// Cipher forces a long source; counted once, not twice
		if (enc || slong)
			m = m - `RFAC_RED_ADDR;
		if (dlong)
			m = m - `RFAC_RED_ADDR;
		if (rfac_app_hdr(hm))
			m = m - (enc ? `RFAC_RED_APP_ENC : `RFAC_RED_APP_PLN);
		// Compatibility overrides every factor but the cipher, which picks 95 or 100
		if (cmp)
			m = enc ? `RFAC_CMP_ENC : `RFAC_CMP_PLN;
		return m;
	endfunction : rfac_max_pay

	logic acc;
	logic src_long;
	logic [63:0] src_addr;
	logic cfg_dlong;
	logic req_dlong;
	logic [63:0] req_dst;
	logic req_bcast;
	logic [6:0] req_max;
	logic [6:0] live_max;
	logic [15:0] app_short;
	logic rx_enc;
	logic rx_slong;

	// Address phase is taken only while the bus is ready
	assign acc = i_hsel && i_htrans[1] && i_hready;

	// Source address selection
	assign src_long = st.cipher_en || rfac_no_short(st.own_short);
	assign src_addr = src_long ? SERIAL : {48'h0, st.own_short};

	// High word 0 and a 16-bit low word mean a short peer
	assign cfg_dlong = (st.dest_hi != 32'h0) || (st.dest_lo[31:16] != 16'h0);

	// Destination taken from config or from the API request
	always_comb
	begin
		if (st.api_mode)
		begin
			req_dlong = (i_hwdata[7:0] != `RFAC_FT_TX16);
			req_dst = req_dlong ? {st.txd_hi, st.txd_lo} : {48'h0, st.txd_lo[15:0]};
		end
		else
		begin
			req_dlong = cfg_dlong;
			req_dst = cfg_dlong ? {st.dest_hi, st.dest_lo} : {48'h0, st.dest_lo[15:0]};
		end
	end

	assign req_bcast = !req_dlong && (req_dst[15:0] == `RFAC_BCAST);
	assign req_max = rfac_max_pay(st.cipher_en, src_long, req_dlong, st.mac_mode,
		st.compat[0]);
	assign live_max = rfac_max_pay(st.cipher_en, src_long, cfg_dlong, st.mac_mode,
		st.compat[0]);

	// Receive descriptor fields
	assign rx_enc = i_hwdata[0];
	assign rx_slong = i_hwdata[1];
	assign app_short = i_hwdata[31:16];

	// Next state: bus phases, register writes, frame decisions
	always_comb
	begin
		nxt_st = st;
		nxt_st.tx_pulse = 1'b0;
		nxt_st.rx_pulse = 1'b0;
		case (st.bus)
			BUS_WR:
			begin
				nxt_st.bus = BUS_IDLE;
				case (st.addr)
					`RFAC_OWN_SHORT:
						nxt_st.own_short = i_hwdata[15:0];
					`RFAC_DEST_HI:
						nxt_st.dest_hi = i_hwdata;
					`RFAC_DEST_LO:
						nxt_st.dest_lo = i_hwdata;
					`RFAC_PAN:
						nxt_st.pan = i_hwdata[15:0];
					`RFAC_CTRL:
					begin
						nxt_st.cipher_en = i_hwdata[0];
						nxt_st.api_mode = i_hwdata[1];
						nxt_st.mac_mode = i_hwdata[3:2];
						nxt_st.compat = i_hwdata[15:8];
					end
					`RFAC_KEY0:
						nxt_st.key[31:0] = i_hwdata;
					`RFAC_KEY1:
						nxt_st.key[63:32] = i_hwdata;
					`RFAC_KEY2:
						nxt_st.key[95:64] = i_hwdata;
					`RFAC_KEY3:
						nxt_st.key[127:96] = i_hwdata;
					`RFAC_TXD_HI:
						nxt_st.txd_hi = i_hwdata;
					`RFAC_TXD_LO:
						nxt_st.txd_lo = i_hwdata;
					`RFAC_ASSOC:
					begin
						if (i_hwdata[0])
							nxt_st.own_short = `RFAC_ASSOC_ADDR;
					end
					`RFAC_TXREQ:
					begin
						// Latch one complete header for the radio side
						nxt_st.tx_pulse = 1'b1;
						nxt_st.tx_src = src_addr;
						nxt_st.tx_slong = src_long;
						nxt_st.tx_dst = req_dst;
						nxt_st.tx_dlong = req_dlong;
						nxt_st.tx_pan = st.pan;
						nxt_st.tx_bpan = (st.pan == `RFAC_BCAST);
						nxt_st.tx_bcast = req_bcast;
						// Acks only for unicast in header modes 0 and 2
						nxt_st.tx_ack = !req_bcast && !st.mac_mode[0];
						nxt_st.tx_sec = st.cipher_en ? `RFAC_SEC_ENC : `RFAC_SEC_OFF;
						nxt_st.tx_app = rfac_app_hdr(st.mac_mode);
						nxt_st.tx_len = i_hwdata[14:8];
						nxt_st.tx_max = req_max;
						// Transparent mode splits data instead of refusing
						nxt_st.tx_rej = st.api_mode && (i_hwdata[14:8] > req_max);
					end
					`RFAC_RXINFO:
					begin
						nxt_st.rx_pulse = 1'b1;
						if (rx_enc != st.cipher_en)
						begin
							nxt_st.rx_drop = 1'b1;
							nxt_st.rx_deliver = 1'b0;
							nxt_st.rx_type = 8'h00;
						end
						else
						begin
							nxt_st.rx_drop = 1'b0;
							nxt_st.rx_deliver = 1'b1;
							if (!st.api_mode)
								nxt_st.rx_type = 8'h00;
							else if (!st.cipher_en)
								nxt_st.rx_type = rx_slong ? `RFAC_FT_RX64 : `RFAC_FT_RX16;
							else if (rfac_app_hdr(st.mac_mode))
								nxt_st.rx_type = rfac_no_short(app_short) ?
									`RFAC_FT_RX64 : `RFAC_FT_RX16;
							else
								nxt_st.rx_type = `RFAC_FT_RX64;
						end
					end
					default:
						nxt_st.bus = BUS_IDLE;
				endcase
			end
			BUS_RD_WAIT:
			begin
				// Extra cycle so a read never sees a stale write
				nxt_st.bus = BUS_RD_DONE;
				case (st.addr)
					`RFAC_OWN_SHORT:
						nxt_st.rdata = {16'h0, st.own_short};
					`RFAC_DEST_HI:
						nxt_st.rdata = st.dest_hi;
					`RFAC_DEST_LO:
						nxt_st.rdata = st.dest_lo;
					`RFAC_PAN:
						nxt_st.rdata = {16'h0, st.pan};
					`RFAC_CTRL:
						nxt_st.rdata = {16'h0, st.compat, 4'h0, st.mac_mode,
							st.api_mode, st.cipher_en};
					`RFAC_TXD_HI:
						nxt_st.rdata = st.txd_hi;
					`RFAC_TXD_LO:
						nxt_st.rdata = st.txd_lo;
					`RFAC_TXSTAT:
						nxt_st.rdata = {6'h0, st.tx_app, st.tx_sec, st.tx_ack,
							st.tx_bpan, st.tx_bcast, st.tx_slong, st.tx_dlong,
							st.tx_rej, st.tx_rej ? `RFAC_FT_TXST : 8'h00,
							st.tx_rej ? `RFAC_ST_BIG : 8'h00};
					`RFAC_TXSRC_HI:
						nxt_st.rdata = st.tx_src[63:32];
					`RFAC_TXSRC_LO:
						nxt_st.rdata = st.tx_src[31:0];
					`RFAC_TXDST_HI:
						nxt_st.rdata = st.tx_dst[63:32];
					`RFAC_TXDST_LO:
						nxt_st.rdata = st.tx_dst[31:0];
					`RFAC_TXPAN:
						nxt_st.rdata = {16'h0, st.tx_pan};
					`RFAC_MAXPAY:
						nxt_st.rdata = {1'h0, st.tx_len, 1'h0, st.tx_max,
							9'h0, live_max};
					`RFAC_RXRES:
						nxt_st.rdata = {22'h0, st.rx_drop, st.rx_deliver, st.rx_type};
					default:
						nxt_st.rdata = 32'h0; // Key and unmapped read zero
				endcase
			end
			BUS_RD_DONE:
				nxt_st.bus = BUS_IDLE;
			default:
				nxt_st.bus = BUS_IDLE;
		endcase
		// New address phase; never taken while a read waits
		if (acc)
		begin
			nxt_st.addr = {i_haddr[7:2], 2'h0};
			nxt_st.bus = i_hwrite ? BUS_WR : BUS_RD_WAIT;
		end
	end

	// State register; clock enable freezes everything but reset
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			st <= '0;
			st.bus <= BUS_IDLE;
			st.own_short <= `RFAC_OWN_RST;
			st.pan <= `RFAC_PAN_RST;
			st.mac_mode <= `RFAC_HMODE_RST;
		end
		else if (i_clk_en)
			st <= nxt_st;
	end

	// Outputs; ready is combinational, data from flops
	assign o_hreadyout = (st.bus != BUS_RD_WAIT);
	assign o_hresp = 1'b0;
	assign o_hrdata = st.rdata;
	assign o_cipher_key = st.key;
	assign o_sec_level = st.cipher_en ? `RFAC_SEC_ENC : `RFAC_SEC_OFF;
	assign o_tx_done = st.tx_pulse;
	assign o_rx_done = st.rx_pulse;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);

	own_long_src_a: assert property (
		rfac_no_short(st.own_short) |-> src_long && src_addr == SERIAL)
		else $error("reserved short address did not select serial");

	enc_long_src_a: assert property (
		o_tx_done && st.tx_sec == `RFAC_SEC_ENC |-> st.tx_slong)
		else $error("encrypted frame without long source");

	enc_cap_a: assert property (
		st.cipher_en && !st.compat[0] |-> live_max <= 7'h69)
		else $error("encrypted payload above 105");

	compat_cap_a: assert property (
		st.cipher_en && st.compat[0] |-> live_max == `RFAC_CMP_ENC)
		else $error("compat encrypted payload not 95");

	bcast_no_ack_a: assert property (
		o_tx_done && st.tx_bcast |-> !st.tx_ack && !st.tx_dlong)
		else $error("broadcast frame asks for ack");

	reject_big_a: assert property (
		o_tx_done |-> st.tx_rej == (st.api_mode && st.tx_len > st.tx_max))
		else $error("oversize rejection wrong");

	assoc_addr_a: assert property (
		i_clk_en && st.bus == BUS_WR && st.addr == `RFAC_ASSOC && i_hwdata[0]
		|=> st.own_short == `RFAC_ASSOC_ADDR && src_long)
		else $error("association did not set FFFE");

	rx_mismatch_a: assert property (
		i_clk_en && st.bus == BUS_WR && st.addr == `RFAC_RXINFO
		&& i_hwdata[0] != st.cipher_en |=> o_rx_done && st.rx_drop && !st.rx_deliver)
		else $error("mismatched cipher data delivered");

	rx_plain_type_a: assert property (
		i_clk_en && st.bus == BUS_WR && st.addr == `RFAC_RXINFO && st.api_mode
		&& st.cipher_en && i_hwdata[0] && !rfac_app_hdr(st.mac_mode)
		|=> st.rx_type == `RFAC_FT_RX64)
		else $error("no app header but type not 0x80");

	read_wait_a: assert property (
		i_clk_en && acc && !i_hwrite |=> !o_hreadyout ##1 (!i_clk_en || o_hreadyout))
		else $error("read wait state wrong");

	// Budget, header and receive type checks; the budget is what the API refusal leans on
	compat_plain_a: assert property (
		!st.cipher_en && st.compat[0] |-> live_max == `RFAC_CMP_PLN)
		else $error("compat plain payload not 100");

	pay_floor_a: assert property (
		!st.compat[0] |-> live_max >= `RFAC_CMP_ENC)
		else $error("payload budget below smallest case");

	short_src_a: assert property (
		o_tx_done && !st.tx_slong |-> st.tx_src[63:16] == 48'h0)
		else $error("short source carries upper bits");

	bcast_pan_a: assert property (
		o_tx_done |-> st.tx_bpan == (st.tx_pan == `RFAC_BCAST))
		else $error("broadcast network flag wrong");

	tx_level_a: assert property (
		o_tx_done |-> st.tx_sec == o_sec_level)
		else $error("frame security level differs from setting");

	rx_plain_api_a: assert property (
		i_clk_en && st.bus == BUS_WR && st.addr == `RFAC_RXINFO && st.api_mode
		&& !st.cipher_en && !i_hwdata[0] |=> st.rx_type ==
		($past(i_hwdata[1]) ? `RFAC_FT_RX64 : `RFAC_FT_RX16))
		else $error("plain receive frame type wrong");

	tx_ok_c: cover property (o_tx_done && !st.tx_rej);
	rx_drop_c: cover property (o_rx_done && st.rx_drop);
	tx_rej_c: cover property (o_tx_done && st.tx_rej);
	rx_short_c: cover property (o_rx_done && st.rx_type == `RFAC_FT_RX16);
	assoc_c: cover property (st.own_short == `RFAC_ASSOC_ADDR);

endmodule : rfac_framer
`default_nettype wire

// >>> src/rfac_map.svh
/*
 Register offsets, reset values, payload budget and frame constants
 for the radio frame addressing and cipher framer.
 Assumes a 32-bit AHB-Lite slave with byte addresses in the low bits.
*/
`ifndef RFAC_MAP_SVH
`define RFAC_MAP_SVH

// Byte offsets
`define RFAC_OWN_SHORT 8'h00
`define RFAC_DEST_HI 8'h04
`define RFAC_DEST_LO 8'h08
`define RFAC_PAN 8'h0C
`define RFAC_CTRL 8'h10
`define RFAC_KEY0 8'h14
`define RFAC_KEY1 8'h18
`define RFAC_KEY2 8'h1C
`define RFAC_KEY3 8'h20
`define RFAC_TXREQ 8'h24
`define RFAC_TXD_HI 8'h28
`define RFAC_TXD_LO 8'h2C
`define RFAC_ASSOC 8'h30
`define RFAC_TXSTAT 8'h34
`define RFAC_TXSRC_HI 8'h38
`define RFAC_TXSRC_LO 8'h3C
`define RFAC_TXDST_HI 8'h40
`define RFAC_TXDST_LO 8'h44
`define RFAC_TXPAN 8'h48
`define RFAC_MAXPAY 8'h4C
`define RFAC_RXINFO 8'h50
`define RFAC_RXRES 8'h54

// Reset values
`define RFAC_OWN_RST 16'h0000
`define RFAC_PAN_RST 16'h0000
`define RFAC_HMODE_RST 2'h0

// Address and frame constants
`define RFAC_BCAST 16'hFFFF
`define RFAC_ASSOC_ADDR 16'hFFFE
`define RFAC_FT_TX64 8'h00
`define RFAC_FT_TX16 8'h01
`define RFAC_FT_RX64 8'h80
`define RFAC_FT_RX16 8'h81
`define RFAC_FT_TXST 8'h89
`define RFAC_ST_BIG 8'h4A
`define RFAC_SEC_OFF 3'h0
`define RFAC_SEC_ENC 3'h4

// Payload budget
`define RFAC_PAY_BASE 7'h74
`define RFAC_RED_ENC 7'h05
`define RFAC_RED_ADDR 7'h06
`define RFAC_RED_APP_ENC 7'h04
`define RFAC_RED_APP_PLN 7'h02
`define RFAC_CMP_ENC 7'h5F
`define RFAC_CMP_PLN 7'h64

`endif

// >>> src/rfac_pkg.sv
/*
 Types for the radio frame addressing and cipher framer.
 Assumes rfac_map.svh is on the include path.
*/
`default_nettype none
package rfac_pkg;
	// Bus phase of the slave
	typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD_WAIT, BUS_RD_DONE} rfac_bus_t;

	// Whole state of the framer
	typedef struct packed {
		rfac_bus_t bus;
		logic [7:0] addr;
		logic [31:0] rdata;
		logic [15:0] own_short;
		logic [31:0] dest_hi;
		logic [31:0] dest_lo;
		logic [15:0] pan;
		logic cipher_en;
		logic api_mode;
		logic [1:0] mac_mode;
		logic [7:0] compat;
		logic [127:0] key;
		logic [31:0] txd_hi;
		logic [31:0] txd_lo;
		logic tx_pulse;
		logic tx_rej;
		logic [63:0] tx_src;
		logic [63:0] tx_dst;
		logic [15:0] tx_pan;
		logic tx_dlong;
		logic tx_slong;
		logic tx_bcast;
		logic tx_bpan;
		logic tx_ack;
		logic [2:0] tx_sec;
		logic tx_app;
		logic [6:0] tx_len;
		logic [6:0] tx_max;
		logic rx_pulse;
		logic rx_deliver;
		logic rx_drop;
		logic [7:0] rx_type;
	} rfac_state_t;
endpackage : rfac_pkg
`default_nettype wire
